// >>> dac_link_cfg.svh
// timing counts and widths for the serial converter link
`ifndef DAC_LINK_CFG_SVH
`define DAC_LINK_CFG_SVH
`define DAC_WORD_BITS 12
`define DAC_CLEAR_CODE 12'h000
// idle pin levels {sclk, cs_n, sdi, ld_n, clear_n} for the sync stages
`define DEV_SYNC_IDLE 5'h0b
`define DAC_FULL_SCALE_MV 4095
`define DAC_MV_PER_STEP 1
`define LINK_HALF_PERIOD_CYCLES 8
`define LINK_GAP_CYCLES 4
`endif

// >>> dac_link_pkg.sv
// shared types for the serial converter link
package dac_link_pkg;
    typedef logic [11:0] code_t;
endpackage : dac_link_pkg

// >>> dac_link_if.sv
// three-wire link plus chip select and clear between host and converter
`timescale 1ns/100ps
interface dac_link_if;
    logic sclk;
    logic chip_sel_n;
    logic serial_data_in;
    logic load_strobe_n;
    logic clear_n;
    modport host (output sclk, chip_sel_n, serial_data_in, load_strobe_n,
        clear_n);
    modport device (input sclk, chip_sel_n, serial_data_in, load_strobe_n,
        clear_n);
endinterface : dac_link_if

// >>> dac_host.sv
// host end: takes 12-bit codes from a two-entry buffer and sends them
`timescale 1ns/100ps
`include "dac_link_cfg.svh"
module dac_host #(
    parameter int HALF = `LINK_HALF_PERIOD_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // code stream in
    input wire logic code_valid,
    input wire dac_link_pkg::code_t code,
    output logic code_ready,
    // user clear request, level, active high
    input wire logic clear_req,
    // link
    dac_link_if.host link
);
    import dac_link_pkg::*;
    initial begin
        if (HALF < 1 || HALF > 255) $error("HALF out of range");
    end
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_SHIFT = 4'b0010,
        S_LOAD = 4'b0100,
        S_GAP = 4'b1000
    } st_e;
    typedef struct packed {
        st_e st;
        code_t buf0;
        code_t buf1;
        logic [1:0] cnt_buf;
        code_t sh;
        logic [3:0] bits;
        logic [7:0] div;
        logic sclk;
        logic cs_n;
        logic sdo;
        logic ld_n;
        logic clr_n;
        logic rdy;
    } h_s;
    h_s q, d;
    logic take;
    logic pop;
    // combinational next state of the whole host
    always_comb begin
        d = q;
        take = code_valid && q.rdy;
        pop = 1'b0;
        d.clr_n = ~clear_req;
        if (q.div != 8'h00) begin
            d.div = q.div - 8'h01;
        end
        case (q.st)
            S_IDLE: begin
                if (q.cnt_buf != 2'h0) begin
                    // select asserted before the first clock
                    d.sh = q.buf0;
                    pop = 1'b1;
                    d.cs_n = 1'b0;
                    d.sdo = q.buf0[11]; // msb first
                    d.bits = 4'h0;
                    d.div = 8'(HALF);
                    d.st = S_SHIFT;
                end
            end
            S_SHIFT: begin
                if (q.div == 8'h00) begin
                    d.div = 8'(HALF);
                    if (!q.sclk) begin
                        d.sclk = 1'b1; // device samples here
                    end else if (q.bits == 4'(`DAC_WORD_BITS - 1)) begin
                        // select rises while the clock is still high: a
                        // select rise with the clock low is a shift edge
                        // deselect, then strobe after full word
                        d.cs_n = 1'b1;
                        d.st = S_LOAD;
                    end else begin
                        d.sclk = 1'b0;
                        d.sh = {q.sh[10:0], 1'b0};
                        d.sdo = q.sh[10];
                        d.bits = q.bits + 4'h1;
                    end
                end
            end
            S_LOAD: begin
                if (q.div == 8'h00) begin
                    d.div = 8'(HALF);
                    if (q.sclk) begin
                        // clock falls with select high, so no edge counts
                        d.sclk = 1'b0;
                    end else if (q.ld_n) begin
                        d.ld_n = 1'b0;
                    end else begin
                        // strobe high before new shifting
                        // no clocking while the strobe is low
                        d.ld_n = 1'b1;
                        d.div = 8'(`LINK_GAP_CYCLES);
                        d.st = S_GAP;
                    end
                end
            end
            S_GAP: begin
                if (q.div == 8'h00) begin
                    d.st = S_IDLE;
                end
            end
            default: d.st = S_IDLE;
        endcase
        // two-entry buffer; ready deasserts when full
        if (pop) begin
            d.buf0 = q.buf1;
        end
        if (take) begin
            if ((q.cnt_buf == 2'h0) || (q.cnt_buf == 2'h1 && pop)) begin
                d.buf0 = code;
            end else begin
                d.buf1 = code;
            end
        end
        d.cnt_buf = q.cnt_buf + {1'b0, take} - {1'b0, pop};
        d.rdy = (d.cnt_buf != 2'h2);
    end
    // state register, everything to idle and lines inactive except clear_n, which reset holds low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{st: S_IDLE, buf0: 12'h000, buf1: 12'h000, cnt_buf: 2'h0,
                sh: 12'h000, bits: 4'h0, div: 8'h00, sclk: 1'b0,
                cs_n: 1'b1, sdo: 1'b0, ld_n: 1'b1, clr_n: 1'b0,
                rdy: 1'b1};
        end else begin
            q <= d;
        end
    end
    assign code_ready = q.rdy;
    assign link.sclk = q.sclk;
    assign link.chip_sel_n = q.cs_n;
    assign link.serial_data_in = q.sdo;
    assign link.load_strobe_n = q.ld_n;
    assign link.clear_n = q.clr_n;
endmodule : dac_host

// >>> dac_device.sv
// converter end: serial register, level latch and clear on sampled pins
// Behaviour
// - select low enables shifting
// - sample data on serial clock rise
// - host sends most significant bit first
// - load strobe copies serial word
// - clear zeroes converter register any time
// - serial register separate from output code
// - host strobes only after full word
// - latch transparent while strobe held low with select high
// - host raises strobe before new shifting
// - output code is unsigned, one millivolt per step
// - select and clock rises are interchangeable
// - strobe fall with select high loads
// - host never clocks while strobe low
`timescale 1ns/100ps
`include "dac_link_cfg.svh"
module dac_device (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // link
    dac_link_if.device link,
    // converter code, millivolts above ground
    output dac_link_pkg::code_t analog_output,
    // word shifted in so far
    output dac_link_pkg::code_t shift_word
);
    import dac_link_pkg::*;
    typedef struct packed {
        logic [4:0] s1; // first stage, read only by s2
        logic [4:0] s2;
        logic [1:0] prev; // last sclk and cs_n after sync
        code_t sh;
        code_t dac;
    } d_s;
    d_s q, d;
    logic sclk_s, cs_s, sdi_s, ld_s, clr_s;
    // pins are asynchronous to clk, so only the second stage is read
    always_comb begin
        d = q;
        d.s1 = {link.sclk, link.chip_sel_n, link.serial_data_in,
            link.load_strobe_n, link.clear_n};
        d.s2 = q.s1;
        {sclk_s, cs_s, sdi_s, ld_s, clr_s} = q.s2;
        d.prev = {sclk_s, cs_s};
        // rise of either line while the other is low
        if ((sclk_s && !q.prev[1] && !cs_s)
            || (cs_s && !q.prev[0] && !sclk_s)) begin
            d.sh = {q.sh[10:0], sdi_s};
        end
        // transparent while low with select high, which also covers the falling edge
        if (!ld_s && cs_s) begin
            d.dac = q.sh;
        end
        // clear after load so it wins; unsigned code drives output
        if (!clr_s) begin
            d.dac = `DAC_CLEAR_CODE;
        end
    end
    // sync stages reset to the idle pin levels, so no false edge follows
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{s1: `DEV_SYNC_IDLE, s2: `DEV_SYNC_IDLE, prev: 2'h1,
                sh: 12'h000, dac: 12'h000};
        end else begin
            q <= d;
        end
    end
    // output straight from the register; clear is synchronised like the
    // other pins, so its zero shows three clocks after the pin falls
    assign analog_output = q.dac;
    assign shift_word = q.sh;
endmodule : dac_device

// >>> dac_link_properties.sv
// assertions on the serial converter link
`timescale 1ns/100ps
module dac_link_properties (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // link
    input wire logic sclk,
    input wire logic chip_sel_n,
    input wire logic serial_data_in,
    input wire logic load_strobe_n,
    input wire logic clear_n,
    // converter outputs
    input wire dac_link_pkg::code_t analog_output,
    input wire dac_link_pkg::code_t shift_word
);
    import dac_link_pkg::*;
    logic [3:0] rises_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence load_seq;
        $fell(load_strobe_n) ##0 clear_n[*6];
    endsequence
    sequence bit_seq;
        $rose(sclk) && !chip_sel_n;
    endsequence
    // clock rises within one frame; counter survives the select rise
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) rises_q <= 4'h0;
        else if ($fell(chip_sel_n)) rises_q <= 4'h0;
        else if ($rose(sclk)) rises_q <= rises_q + 4'h1;
    end
    clear_zero_a: assert property (
        !clear_n[*4] |-> analog_output == 12'h000) else $error("clear leak");
    load_copy_a: assert property (
        load_seq |-> analog_output == shift_word) else $error("no load");
    out_hold_a: assert property (
        (load_strobe_n && clear_n)[*4] |=> $stable(analog_output))
        else $error("output moved");
    bit_shift_a: assert property (
        bit_seq |-> ##4 shift_word[0] == $past(serial_data_in, 4))
        else $error("bit lost");
    idle_hold_a: assert property (
        chip_sel_n[*8] |-> $stable(shift_word)) else $error("idle shift");
    word_len_a: assert property (
        $rose(chip_sel_n) |-> rises_q == 4'hc) else $error("bad count");
    strobe_late_a: assert property (
        !load_strobe_n |-> chip_sel_n && !sclk) else $error("early load");
    strobe_up_a: assert property (
        $fell(chip_sel_n) |-> load_strobe_n) else $error("strobe low");
endmodule : dac_link_properties

// >>> serial_dac_input_latch_tb_top.sv
// bench joining host and converter ends over one link
`timescale 1ns/100ps
module serial_dac_input_latch_tb_top;
    import dac_link_pkg::*;
    logic clk = 0;
    logic rst_b = 0;
    logic code_valid = 0;
    logic clear_req = 0;
    logic code_ready;
    code_t code = 12'h000;
    code_t analog_output;
    code_t shift_word;
    code_t wire_q = 12'h000;
    code_t exp_q[$];
    int mismatches = 0;
    int comparisons = 0;
    int n;
    dac_link_if link();
    // short half period keeps the run brief; device needs at least 2
    dac_host #(.HALF(4)) u_dac_host (.clk(clk), .rst_b(rst_b),
        .code_valid(code_valid), .code(code), .code_ready(code_ready),
        .clear_req(clear_req), .link(link));
    dac_device u_dac_device (.clk(clk), .rst_b(rst_b), .link(link),
        .analog_output(analog_output), .shift_word(shift_word));
    dac_link_properties u_dac_link_properties (.clk(clk), .rst_b(rst_b),
        .sclk(link.sclk), .chip_sel_n(link.chip_sel_n),
        .serial_data_in(link.serial_data_in),
        .load_strobe_n(link.load_strobe_n), .clear_n(link.clear_n),
        .analog_output(analog_output), .shift_word(shift_word));
    always #5 clk = ~clk;
    task automatic check(input string nm, input code_t e, input code_t s);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task final_report;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    // waits out a full buffer, so the fourth word of a burst is held until a slot frees
    task automatic send(input code_t v);
        code = v;
        for (n = 0; n < 2000 && code_ready !== 1'b1; n++) @(negedge clk);
        if (n == 2000) begin
            mismatches++;
            final_report();
        end
        exp_q.push_back(v);
        @(negedge clk);
    endtask : send
    task automatic idle;
        for (n = 0; n < 5000 && exp_q.size() != 0; n++) @(negedge clk);
        if (n == 5000) begin
            mismatches++;
            final_report();
        end
        repeat (20) @(negedge clk);
    endtask : idle
    // rebuild the word from the wire, first bit into the top
    always @(posedge link.sclk) if (!link.chip_sel_n)
        wire_q = {wire_q[10:0], link.serial_data_in};
    // each strobe release retires the oldest expected word
    always @(posedge link.load_strobe_n) if (rst_b && exp_q.size() != 0) begin
        @(negedge clk);
        check("wire word", exp_q[0], wire_q);
        check("analog_output", exp_q.pop_front(), analog_output);
    end
    initial begin
        code_t tbl[5] = '{12'h000, 12'hfff, 12'h801, 12'h800, 12'h7ff};
        void'($urandom(55587));
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        code_valid = 1'b1;
        foreach (tbl[i]) send(tbl[i]);
        repeat (4) send(code_t'($urandom()));
        code_valid = 1'b0;
        idle();
        clear_req = 1'b1;
        repeat (6) @(negedge clk);
        check("cleared output", 12'h000, analog_output);
        clear_req = 1'b0;
        repeat (10) @(negedge clk);
        check("latched zero", 12'h000, analog_output);
        code_valid = 1'b1;
        send(12'h5a3);
        code_valid = 1'b0;
        idle();
        final_report();
    end
endmodule : serial_dac_input_latch_tb_top
